// >>> twsb_pkg.sv
// Purpose: Shared constants and types for the two-wire slave bus front end.
// Assumes: Link-side logic oversamples the bus on a free-running link clock.
// Notes: Cycle counts derive from the nanosecond figures and the link clock period.
package twsb_pkg;
	localparam int CORE_PERIOD_NS = 40;
	localparam int LINK_PERIOD_NS = 32;
	// Longest spike that must be ignored on either bus line.
	localparam int SPIKE_NS = 50;
	// Least hold of the data output after a falling clock edge.
	localparam int HOLD_NS = 300;
	// A spike of SPIKE_NS can cover at most this many link samples.
	localparam int SPIKE_SAMPLES = (SPIKE_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
	localparam logic [3:0] FILT_CYC = 4'(SPIKE_SAMPLES + 1);
	localparam logic [3:0] HOLD_CYC = 4'((HOLD_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] LAST_TX_FALL = 4'h7;
	localparam int RW_BIT_POS = 0;
	// Byte sent when the user has no data ready: all ones keeps the line released.
	localparam logic [7:0] IDLE_BYTE = 8'hFF;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RECV,
		ST_ACK_OUT,
		ST_SEND,
		ST_ACK_IN
	} twsb_state_type;
endpackage

// >>> twsb_sync.sv
// Purpose: Three-flop synchroniser; a change is taken once the last two stages agree.
// Assumes: Each bit is an independent level or toggle.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ns
module twsb_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	// Clock and control
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic en_i,
	// Data
	input wire logic [WIDTH-1:0] din_i,
	output logic [WIDTH-1:0] dout_o
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] mid_ff;
	logic [WIDTH-1:0] late_ff;
	logic [WIDTH-1:0] out_ff;
	logic [WIDTH-1:0] nxt_out;
	logic [WIDTH-1:0] agree;

	always_comb begin
		agree = ~(mid_ff ^ late_ff);
		nxt_out = (late_ff & agree) | (out_ff & ~agree);
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			meta_ff <= RESET_VAL;
			mid_ff <= RESET_VAL;
			late_ff <= RESET_VAL;
			out_ff <= RESET_VAL;
		end else if (en_i) begin
			meta_ff <= din_i;
			mid_ff <= meta_ff;
			late_ff <= mid_ff;
			out_ff <= nxt_out;
		end
	end

	assign dout_o = out_ff;
endmodule // twsb_sync

// >>> twsb_spike_filter.sv
// Purpose: Ignores pulses shorter than STABLE_CYC samples on one synchronised line.
// Assumes: Input is already synchronised to clk_i.
// Notes: Adds STABLE_CYC cycles of latency to every genuine edge.
`timescale 1ns/1ns
module twsb_spike_filter #(
	parameter logic [3:0] STABLE_CYC = 4'h3,
	parameter logic RESET_VAL = 1'b1
) (
	// Clock and control
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic en_i,
	// Line
	input wire logic din_i,
	output logic dout_o
);
	logic out_ff;
	logic [3:0] cnt_ff;
	logic nxt_out;
	logic [3:0] nxt_cnt;

	always_comb begin
		nxt_out = out_ff;
		nxt_cnt = cnt_ff;
		if (din_i == out_ff) begin
			nxt_cnt = 4'h0;
		end else if (cnt_ff == STABLE_CYC - 4'h1) begin
			nxt_out = din_i;
			nxt_cnt = 4'h0;
		end else begin
			nxt_cnt = cnt_ff + 4'h1;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			out_ff <= RESET_VAL;
			cnt_ff <= 4'h0;
		end else if (en_i) begin
			out_ff <= nxt_out;
			cnt_ff <= nxt_cnt;
		end
	end

	assign dout_o = out_ff;
endmodule // twsb_spike_filter

// >>> twsb_bus_slave.sv
// Purpose: Bus front end of a two-wire serial slave: conditions, bits, bytes, acknowledge.
// Assumes: The master makes the serial clock and all Start and Stop conditions.
// Notes: Bus logic runs on link_clk_i; bytes and events cross to core_clk_i by toggles.
// Behaviour
// - Data pin open-drain: pull low or release.
// - Data changes only while serial clock low.
// - Data falling while clock high is Start.
// - Data rising while clock high is Stop.
// - Bus idle while both lines high.
// - One data bit per clock pulse after Start.
// - Any number of bytes per transfer.
// - Hold data output 300 ns after clock fall.
// - Ignore spikes of 50 ns or less.
// - Receiver acknowledges each byte on ninth pulse.
// - No acknowledge while programming cycle runs.
// - Master no-acknowledge makes device release line.
// - Control byte last bit selects read/write.
`timescale 1ns/1ns
module twsb_bus_slave (
	// Core clock domain
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic clk_en_i,
	// Link clock domain
	input wire logic link_clk_i,
	// Bus pins
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	// Received bytes and bus events
	output logic [7:0] rx_data_o,
	output logic rx_valid_o,
	output logic rx_ctrl_o,
	output logic rx_read_o,
	output logic start_o,
	output logic stop_o,
	output logic bus_idle_o,
	// Acknowledge control
	input wire logic ack_en_i,
	input wire logic prog_busy_i,
	// Bytes to send
	input wire logic [7:0] tx_data_i,
	input wire logic tx_valid_i,
	output logic tx_ready_o
);
	localparam logic [5:0] LSYNC_RESET = 6'h30;

	// Link domain reset release, held until two link edges after rstn_i rises.
	logic lrst_meta_ff;
	logic lrst_n_ff;
	always_ff @(posedge link_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			lrst_meta_ff <= 1'b0;
			lrst_n_ff <= 1'b0;
		end else begin
			lrst_meta_ff <= 1'b1;
			lrst_n_ff <= lrst_meta_ff;
		end
	end

	logic tx_req_tog_ff;
	logic [7:0] tx_hold_ff;
	logic [5:0] lsync;
	logic len;
	logic ack_en_s;
	logic busy_s;
	logic tx_req_s;
	logic scl_f;
	logic sda_f;

	twsb_sync #(.WIDTH(6), .RESET_VAL(LSYNC_RESET)) u_link_sync (
		.clk_i(link_clk_i),
		.rstn_i(lrst_n_ff),
		.en_i(1'b1),
		.din_i({scl_i, sda_i, clk_en_i, ack_en_i, prog_busy_i, tx_req_tog_ff}),
		.dout_o(lsync)
	);
	assign len = lsync[3];
	assign ack_en_s = lsync[2];
	assign busy_s = lsync[1];
	assign tx_req_s = lsync[0];

	twsb_spike_filter #(.STABLE_CYC(twsb_pkg::FILT_CYC), .RESET_VAL(1'b1)) u_scl_filt (
		.clk_i(link_clk_i),
		.rstn_i(lrst_n_ff),
		.en_i(len),
		.din_i(lsync[5]),
		.dout_o(scl_f)
	);
	twsb_spike_filter #(.STABLE_CYC(twsb_pkg::FILT_CYC), .RESET_VAL(1'b1)) u_sda_filt (
		.clk_i(link_clk_i),
		.rstn_i(lrst_n_ff),
		.en_i(len),
		.din_i(lsync[4]),
		.dout_o(sda_f)
	);

	// Link domain state.
	twsb_pkg::twsb_state_type state_ff, nxt_state;
	logic [3:0] bit_cnt_ff, nxt_bit_cnt;
	logic [3:0] hold_cnt_ff, nxt_hold_cnt;
	logic [7:0] shift_ff, nxt_shift;
	logic [7:0] rx_buf_ff, nxt_rx_buf;
	logic [7:0] tx_buf_ff, nxt_tx_buf;
	logic first_ff, nxt_first;
	logic rw_ff, nxt_rw;
	logic drive_ff, nxt_drive;
	logic pend_drive_ff, nxt_pend_drive;
	logic scl_q_ff, sda_q_ff;
	logic rx_ctrl_buf_ff, nxt_rx_ctrl_buf;
	logic rx_tog_ff, nxt_rx_tog;
	logic start_tog_ff, nxt_start_tog;
	logic stop_tog_ff, nxt_stop_tog;
	logic have_tx_ff, nxt_have_tx;
	logic tx_seen_ff, nxt_tx_seen;
	logic tx_ack_tog_ff, nxt_tx_ack_tog;
	logic idle_ff, nxt_idle;
	logic start_det, stop_det, scl_rise, scl_fall;
	logic [7:0] next_tx;

	always_comb begin
		start_det = scl_f & scl_q_ff & sda_q_ff & ~sda_f;
		stop_det = scl_f & scl_q_ff & ~sda_q_ff & sda_f;
		scl_rise = scl_f & ~scl_q_ff;
		scl_fall = ~scl_f & scl_q_ff;
		next_tx = have_tx_ff ? tx_buf_ff : twsb_pkg::IDLE_BYTE;
		nxt_state = state_ff;
		nxt_bit_cnt = bit_cnt_ff;
		nxt_hold_cnt = hold_cnt_ff;
		nxt_shift = shift_ff;
		nxt_rx_buf = rx_buf_ff;
		nxt_tx_buf = tx_buf_ff;
		nxt_first = first_ff;
		nxt_rw = rw_ff;
		nxt_drive = drive_ff;
		nxt_pend_drive = pend_drive_ff;
		nxt_rx_ctrl_buf = rx_ctrl_buf_ff;
		nxt_rx_tog = rx_tog_ff;
		nxt_start_tog = start_tog_ff;
		nxt_stop_tog = stop_tog_ff;
		nxt_have_tx = have_tx_ff;
		nxt_tx_seen = tx_seen_ff;
		nxt_tx_ack_tog = tx_ack_tog_ff;
		nxt_idle = scl_f & sda_f & (state_ff == twsb_pkg::ST_IDLE);
		// Output changes wait out the hold time after the clock fall.
		if (hold_cnt_ff != 4'h0) begin
			nxt_hold_cnt = hold_cnt_ff - 4'h1;
			if (hold_cnt_ff == 4'h1) begin
				nxt_drive = pend_drive_ff;
			end
		end
		if (start_det) begin
			nxt_state = twsb_pkg::ST_RECV;
			nxt_bit_cnt = 4'h0;
			nxt_first = 1'b1;
			nxt_drive = 1'b0;
			nxt_hold_cnt = 4'h0;
			nxt_start_tog = ~start_tog_ff;
		end else if (stop_det) begin
			nxt_state = twsb_pkg::ST_IDLE;
			nxt_drive = 1'b0;
			nxt_hold_cnt = 4'h0;
			nxt_stop_tog = ~stop_tog_ff;
		end else begin
			case (state_ff)
				twsb_pkg::ST_IDLE: begin
				end
				twsb_pkg::ST_RECV: begin
					if (scl_rise) begin
						nxt_shift = {shift_ff[6:0], sda_f};
						nxt_bit_cnt = bit_cnt_ff + 4'h1;
					end else if (scl_fall && bit_cnt_ff == twsb_pkg::BYTE_BITS) begin
						nxt_rx_buf = shift_ff;
						nxt_rx_ctrl_buf = first_ff;
						nxt_rx_tog = ~rx_tog_ff;
						nxt_bit_cnt = 4'h0;
						if (first_ff) begin
							nxt_rw = shift_ff[twsb_pkg::RW_BIT_POS];
						end
						if (ack_en_s && !busy_s) begin
							nxt_pend_drive = 1'b1;
							nxt_hold_cnt = twsb_pkg::HOLD_CYC;
							nxt_state = twsb_pkg::ST_ACK_OUT;
						end else begin
							nxt_state = twsb_pkg::ST_IDLE;
						end
					end
				end
				twsb_pkg::ST_ACK_OUT: begin
					if (scl_fall) begin
						nxt_first = 1'b0;
						nxt_hold_cnt = twsb_pkg::HOLD_CYC;
						if (first_ff && rw_ff) begin
							nxt_state = twsb_pkg::ST_SEND;
							nxt_shift = next_tx;
							nxt_have_tx = 1'b0;
							nxt_pend_drive = ~next_tx[7];
						end else begin
							nxt_state = twsb_pkg::ST_RECV;
							nxt_pend_drive = 1'b0;
						end
					end
				end
				twsb_pkg::ST_SEND: begin
					if (scl_fall) begin
						nxt_hold_cnt = twsb_pkg::HOLD_CYC;
						if (bit_cnt_ff == twsb_pkg::LAST_TX_FALL) begin
							nxt_state = twsb_pkg::ST_ACK_IN;
							nxt_bit_cnt = 4'h0;
							nxt_pend_drive = 1'b0;
						end else begin
							nxt_bit_cnt = bit_cnt_ff + 4'h1;
							nxt_shift = {shift_ff[6:0], 1'b1};
							nxt_pend_drive = ~shift_ff[6];
						end
					end
				end
				twsb_pkg::ST_ACK_IN: begin
					if (scl_rise) begin
						if (sda_f) begin
							nxt_state = twsb_pkg::ST_IDLE;
						end else begin
							nxt_bit_cnt = 4'h1;
						end
					end else if (scl_fall && bit_cnt_ff == 4'h1) begin
						nxt_state = twsb_pkg::ST_SEND;
						nxt_bit_cnt = 4'h0;
						nxt_shift = next_tx;
						nxt_have_tx = 1'b0;
						nxt_pend_drive = ~next_tx[7];
						nxt_hold_cnt = twsb_pkg::HOLD_CYC;
					end
				end
				default: begin
					nxt_state = twsb_pkg::ST_IDLE;
					nxt_drive = 1'b0;
				end
			endcase
		end
		// The user's byte is only taken while the link buffer is free, so the core stalls.
		// It comes after the state update so a byte arriving as a send begins is kept.
		if (tx_req_s != tx_seen_ff && !have_tx_ff) begin
			nxt_tx_buf = tx_hold_ff;
			nxt_have_tx = 1'b1;
			nxt_tx_seen = tx_req_s;
			nxt_tx_ack_tog = ~tx_ack_tog_ff;
		end
	end

	always_ff @(posedge link_clk_i or negedge lrst_n_ff) begin
		if (!lrst_n_ff) begin
			state_ff <= twsb_pkg::ST_IDLE;
			bit_cnt_ff <= 4'h0;
			hold_cnt_ff <= 4'h0;
			shift_ff <= 8'h00;
			rx_buf_ff <= 8'h00;
			tx_buf_ff <= 8'h00;
			first_ff <= 1'b0;
			rw_ff <= 1'b0;
			drive_ff <= 1'b0;
			pend_drive_ff <= 1'b0;
			scl_q_ff <= 1'b1;
			sda_q_ff <= 1'b1;
			rx_ctrl_buf_ff <= 1'b0;
			rx_tog_ff <= 1'b0;
			start_tog_ff <= 1'b0;
			stop_tog_ff <= 1'b0;
			have_tx_ff <= 1'b0;
			tx_seen_ff <= 1'b0;
			tx_ack_tog_ff <= 1'b0;
			idle_ff <= 1'b0;
		end else if (len) begin
			state_ff <= nxt_state;
			bit_cnt_ff <= nxt_bit_cnt;
			hold_cnt_ff <= nxt_hold_cnt;
			shift_ff <= nxt_shift;
			rx_buf_ff <= nxt_rx_buf;
			tx_buf_ff <= nxt_tx_buf;
			first_ff <= nxt_first;
			rw_ff <= nxt_rw;
			drive_ff <= nxt_drive;
			pend_drive_ff <= nxt_pend_drive;
			scl_q_ff <= scl_f;
			sda_q_ff <= sda_f;
			rx_ctrl_buf_ff <= nxt_rx_ctrl_buf;
			rx_tog_ff <= nxt_rx_tog;
			start_tog_ff <= nxt_start_tog;
			stop_tog_ff <= nxt_stop_tog;
			have_tx_ff <= nxt_have_tx;
			tx_seen_ff <= nxt_tx_seen;
			tx_ack_tog_ff <= nxt_tx_ack_tog;
			idle_ff <= nxt_idle;
		end
	end

	// The pin is only ever pulled low; the pull-up makes the high level.
	assign sda_o = 1'b0;
	assign sda_oe_o = drive_ff;

	// Core domain: events and bytes arrive as toggles; data words are stable when seen.
	logic [4:0] csync;
	twsb_sync #(.WIDTH(5), .RESET_VAL(5'h00)) u_core_sync (
		.clk_i(core_clk_i),
		.rstn_i(rstn_i),
		.en_i(clk_en_i),
		.din_i({rx_tog_ff, start_tog_ff, stop_tog_ff, tx_ack_tog_ff, idle_ff}),
		.dout_o(csync)
	);

	logic [7:0] rx_data_ff, nxt_rx_data;
	logic rx_valid_ff, nxt_rx_valid;
	logic rx_ctrl_ff, nxt_rx_ctrl;
	logic rx_read_ff, nxt_rx_read;
	logic start_ff, stop_ff;
	logic nxt_start, nxt_stop;
	logic [3:0] seen_ff;
	logic pend_ff, nxt_pend;
	logic nxt_tx_req_tog;
	logic [7:0] nxt_tx_hold;

	always_comb begin
		nxt_rx_data = rx_data_ff;
		nxt_rx_ctrl = rx_ctrl_ff;
		nxt_rx_read = rx_read_ff;
		nxt_rx_valid = csync[4] != seen_ff[3];
		nxt_start = csync[3] != seen_ff[2];
		nxt_stop = csync[2] != seen_ff[1];
		nxt_pend = pend_ff;
		nxt_tx_req_tog = tx_req_tog_ff;
		nxt_tx_hold = tx_hold_ff;
		if (nxt_rx_valid) begin
			nxt_rx_data = rx_buf_ff;
			nxt_rx_ctrl = rx_ctrl_buf_ff;
			if (rx_ctrl_buf_ff) begin
				nxt_rx_read = rx_buf_ff[twsb_pkg::RW_BIT_POS];
			end
		end
		if (csync[1] != seen_ff[0]) begin
			nxt_pend = 1'b0;
		end
		if (tx_valid_i && !pend_ff) begin
			nxt_pend = 1'b1;
			nxt_tx_hold = tx_data_i;
			nxt_tx_req_tog = ~tx_req_tog_ff;
		end
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rx_data_ff <= 8'h00;
			rx_valid_ff <= 1'b0;
			rx_ctrl_ff <= 1'b0;
			rx_read_ff <= 1'b0;
			start_ff <= 1'b0;
			stop_ff <= 1'b0;
			seen_ff <= 4'h0;
			pend_ff <= 1'b0;
			tx_req_tog_ff <= 1'b0;
			tx_hold_ff <= 8'h00;
		end else if (clk_en_i) begin
			rx_data_ff <= nxt_rx_data;
			rx_valid_ff <= nxt_rx_valid;
			rx_ctrl_ff <= nxt_rx_ctrl;
			rx_read_ff <= nxt_rx_read;
			start_ff <= nxt_start;
			stop_ff <= nxt_stop;
			seen_ff <= csync[4:1];
			pend_ff <= nxt_pend;
			tx_req_tog_ff <= nxt_tx_req_tog;
			tx_hold_ff <= nxt_tx_hold;
		end
	end

	assign rx_data_o = rx_data_ff;
	assign rx_valid_o = rx_valid_ff;
	assign rx_ctrl_o = rx_ctrl_ff;
	assign rx_read_o = rx_read_ff;
	assign start_o = start_ff;
	assign stop_o = stop_ff;
	assign bus_idle_o = csync[0];
	assign tx_ready_o = ~pend_ff;

	AST_START_RESTART: assert property (@(posedge link_clk_i) disable iff (!lrst_n_ff)
		(len && start_det) |=> (state_ff == twsb_pkg::ST_RECV && bit_cnt_ff == 4'h0 && !drive_ff))
		else $error("Start did not restart byte reception");
	AST_STOP_RELEASE: assert property (@(posedge link_clk_i) disable iff (!lrst_n_ff)
		(len && stop_det) |=> (state_ff == twsb_pkg::ST_IDLE && !drive_ff && stop_tog_ff != $past(stop_tog_ff)))
		else $error("Stop did not release the line and idle");
	AST_HOLD_EDGE: assert property (@(posedge link_clk_i) disable iff (!lrst_n_ff)
		($changed(drive_ff) && !$past(start_det || stop_det)) |-> ($past(hold_cnt_ff) == 4'h1))
		else $error("Data output changed outside the hold window");
	AST_CHANGE_LOW: assert property (@(posedge link_clk_i) disable iff (!lrst_n_ff)
		($changed(drive_ff) && !$past(start_det || stop_det)) |-> !scl_f)
		else $error("Data output changed while clock high");
	AST_BIT_COUNT: assert property (@(posedge link_clk_i) disable iff (!lrst_n_ff)
		(len && state_ff == twsb_pkg::ST_RECV && scl_rise && !start_det && !stop_det)
		|=> (bit_cnt_ff == $past(bit_cnt_ff) + 4'h1 && shift_ff[0] == $past(sda_f)))
		else $error("Clock pulse did not take exactly one bit");
	AST_BUSY_NO_ACK: assert property (@(posedge link_clk_i) disable iff (!lrst_n_ff)
		(len && state_ff == twsb_pkg::ST_RECV && scl_fall && bit_cnt_ff == twsb_pkg::BYTE_BITS
		&& busy_s && !start_det && !stop_det) |=> (state_ff == twsb_pkg::ST_IDLE && !drive_ff))
		else $error("Acknowledge given while busy");
	AST_ACK_DRIVE: assert property (@(posedge link_clk_i) disable iff (!lrst_n_ff)
		(len && state_ff == twsb_pkg::ST_ACK_OUT && hold_cnt_ff == 4'h1 && !start_det && !stop_det)
		|=> drive_ff)
		else $error("Acknowledge not driven low");
	AST_NACK_IDLE: assert property (@(posedge link_clk_i) disable iff (!lrst_n_ff)
		(len && state_ff == twsb_pkg::ST_ACK_IN && scl_rise && sda_f && !start_det && !stop_det)
		|=> (state_ff == twsb_pkg::ST_IDLE && !drive_ff))
		else $error("No-acknowledge did not end transmission");
	AST_READ_SELECT: assert property (@(posedge link_clk_i) disable iff (!lrst_n_ff)
		(len && state_ff == twsb_pkg::ST_ACK_OUT && scl_fall && first_ff && !start_det && !stop_det)
		|=> (state_ff == (rw_ff ? twsb_pkg::ST_SEND : twsb_pkg::ST_RECV)))
		else $error("Direction bit not honoured");
endmodule // twsb_bus_slave

// >>> twsb_master_model.sv
// Purpose: Behavioural two-wire bus master that makes the serial clock and all conditions.
// Assumes: The data line is open drain and the bench resolves it with a pull-up; the clock is driven directly.
// Notes: The serial clock stands high between frames; spike_en adds a 40 ns clock spike.
`timescale 1ns/1ns
module twsb_master_model #(
	parameter int HALF_NS = 1000
) (
	// Bus lines
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_low_o
);
	logic spike_en;
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
		spike_en = 1'b0;
	end
	task automatic start_cond();
		sda_low_o = 1'b0;
		#(HALF_NS) scl_o = 1'b1;
		#(HALF_NS) sda_low_o = 1'b1;
		#(HALF_NS) scl_o = 1'b0;
	endtask
	task automatic stop_cond();
		#(HALF_NS/2) sda_low_o = 1'b1;
		#(HALF_NS/2) scl_o = 1'b1;
		#(HALF_NS) sda_low_o = 1'b0;
		#(HALF_NS);
	endtask
	// The spike sits well after the real fall so it cannot stretch it.
	task automatic bit_xfer(input logic b, output logic r);
		if (spike_en) begin
			#300 scl_o = 1'b1;
			#40 scl_o = 1'b0;
			#(HALF_NS/2 - 340);
		end else begin
			#(HALF_NS/2);
		end
		sda_low_o = !b;
		#(HALF_NS/2) scl_o = 1'b1;
		#(HALF_NS/2) r = sda_i;
		#(HALF_NS/2) scl_o = 1'b0;
	endtask
	task automatic byte_xfer(input logic [7:0] d, input logic ack_b, output logic [7:0] r,
		output logic ack_r);
		for (int i = 7; i >= 0; i--) begin
			bit_xfer(d[i], r[i]);
		end
		bit_xfer(ack_b, ack_r);
	endtask
	task automatic sda_glitch();
		sda_low_o = 1'b1;
		#40 sda_low_o = 1'b0;
		#(HALF_NS);
	endtask
endmodule // twsb_master_model

// >>> test_two_wire_slave_bus_conditions.sv
// Purpose: Self-checking bench for the two-wire slave bus front end.
// Assumes: The master model drives the bus; core inputs change at the falling core edge.
// Notes: Event pulses are counted on the core clock and compared as differences.
`timescale 1ns/1ns
module test_two_wire_slave_bus_conditions;
	logic core_clk, link_clk, rstn, ack_en, prog_busy, tx_valid, m_scl, m_low;
	logic [7:0] tx_data, rx_data, rx_last, r;
	logic sda_o, sda_oe, rx_valid, rx_ctrl, rx_read, start_p, stop_p, bus_idle, tx_ready;
	logic ctrl_last, read_last, a, clk_en;
	wire logic sda_w;
	int fail_count, total_checks, start_n, stop_n, rx_n, s, p, n;
	time t_fall, t_rise;
	assign sda_w = ~((sda_oe && !sda_o) || m_low);
	twsb_master_model m (.sda_i(sda_w), .scl_o(m_scl), .sda_low_o(m_low));
	twsb_bus_slave dut (.core_clk_i(core_clk), .rstn_i(rstn), .clk_en_i(clk_en),
		.link_clk_i(link_clk), .scl_i(m_scl), .sda_i(sda_w), .sda_o(sda_o),
		.sda_oe_o(sda_oe), .rx_data_o(rx_data), .rx_valid_o(rx_valid), .rx_ctrl_o(rx_ctrl),
		.rx_read_o(rx_read), .start_o(start_p), .stop_o(stop_p), .bus_idle_o(bus_idle),
		.ack_en_i(ack_en), .prog_busy_i(prog_busy), .tx_data_i(tx_data),
		.tx_valid_i(tx_valid), .tx_ready_o(tx_ready));
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	initial begin
		link_clk = 1'b0;
		#7;
		forever #16 link_clk = ~link_clk;
	end
	// Pulses are sampled mid-cycle, away from the edge that launches them.
	always @(negedge core_clk) begin
		if (start_p === 1'b1) start_n++;
		if (stop_p === 1'b1) stop_n++;
		if (rx_valid === 1'b1) begin
			rx_n++;
			rx_last = rx_data;
			ctrl_last = rx_ctrl;
			read_last = rx_read;
		end
	end
	// A fall that ends a clock high shorter than 100 ns is a spike, not a real fall.
	always @(posedge m_scl) t_rise = $time;
	always @(negedge m_scl) if ($time - t_rise > 100) t_fall = $time;
	always @(sda_oe) if (rstn === 1'b1) check("hold", 8'(($time - t_fall >= 300) && !m_scl), 8'h01);
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic load_tx(input logic [7:0] d);
		int i;
		@(negedge core_clk);
		tx_data = d;
		tx_valid = 1'b1;
		for (i = 0; i < 100; i++) begin
			@(posedge core_clk);
			if (tx_ready === 1'b1) break;
		end
		@(negedge core_clk);
		tx_valid = 1'b0;
		if (i == 100) begin
			fail_count++;
			stop_test();
		end
	endtask
	task automatic wait_idle();
		int i;
		for (i = 0; i < 200 && bus_idle !== 1'b1; i++) @(posedge core_clk);
		if (i == 200) begin
			fail_count++;
			stop_test();
		end
	endtask
	task automatic test_idle();
		wait_idle();
		check("bus_idle", 8'(bus_idle), 8'h01);
		check("sda_o", 8'(sda_o), 8'h00);
		check("oe idle", 8'(sda_oe), 8'h00);
		s = start_n;
		m.sda_glitch();
		#2000 check("glitch start", 8'(start_n - s), 8'h00);
		check("bus_idle", 8'(bus_idle), 8'h01);
		$display("test idle done");
	endtask
	task automatic test_write();
		s = start_n;
		p = stop_n;
		n = rx_n;
		m.start_cond();
		m.byte_xfer(8'hA0, 1'b1, r, a);
		check("start", 8'(start_n - s), 8'h01);
		check("ack", 8'(a), 8'h00);
		check("rx ctrl byte", rx_last, 8'hA0);
		check("ctrl", 8'(ctrl_last), 8'h01);
		check("read", 8'(read_last), 8'h00);
		m.spike_en = 1'b1;
		m.byte_xfer(8'h5A, 1'b1, r, a);
		m.spike_en = 1'b0;
		check("rx spiked", rx_last, 8'h5A);
		check("ctrl", 8'(ctrl_last), 8'h00);
		m.byte_xfer(8'h3C, 1'b1, r, a);
		check("rx byte", rx_last, 8'h3C);
		check("rx count", 8'(rx_n - n), 8'h03);
		m.stop_cond();
		#2000 check("stop", 8'(stop_n - p), 8'h01);
		check("oe after stop", 8'(sda_oe), 8'h00);
		check("idle after stop", 8'(bus_idle), 8'h01);
		$display("test write done");
	endtask
	task automatic test_restart_read();
		load_tx(8'hC3);
		m.start_cond();
		repeat (3) m.bit_xfer(1'b1, a);
		n = rx_n;
		m.start_cond();
		m.byte_xfer(8'hA1, 1'b1, r, a);
		check("ack", 8'(a), 8'h00);
		check("rx after restart", rx_last, 8'hA1);
		check("rx count", 8'(rx_n - n), 8'h01);
		check("ctrl", 8'(ctrl_last), 8'h01);
		check("read", 8'(read_last), 8'h01);
		m.byte_xfer(8'hFF, 1'b0, r, a);
		check("tx byte", r, 8'hC3);
		m.byte_xfer(8'hFF, 1'b1, r, a);
		check("idle byte", r, twsb_pkg::IDLE_BYTE);
		#1000 check("oe after nack", 8'(sda_oe), 8'h00);
		m.stop_cond();
		wait_idle();
		$display("test restart read done");
	endtask
	task automatic test_refuse();
		for (int i = 0; i < 2; i++) begin
			@(negedge core_clk);
			ack_en = (i == 1);
			prog_busy = (i == 1);
			m.start_cond();
			m.byte_xfer(8'hA0, 1'b1, r, a);
			check("no ack", 8'(a), 8'h01);
			m.stop_cond();
			wait_idle();
		end
		@(negedge core_clk);
		ack_en = 1'b1;
		prog_busy = 1'b0;
		$display("test refuse done");
	endtask
	// Conditions made while the clock enable is low must leave no trace.
	task automatic test_freeze();
		@(negedge core_clk);
		clk_en = 1'b0;
		s = start_n;
		p = stop_n;
		#500;
		m.start_cond();
		m.stop_cond();
		check("frozen start", 8'(start_n - s), 8'h00);
		check("frozen stop", 8'(stop_n - p), 8'h00);
		@(negedge core_clk);
		clk_en = 1'b1;
		#2000 check("thawed start", 8'(start_n - s), 8'h00);
		check("thawed stop", 8'(stop_n - p), 8'h00);
		check("thawed idle", 8'(bus_idle), 8'h01);
		$display("test freeze done");
	endtask
	initial begin
		rstn = 1'b0;
		clk_en = 1'b1;
		ack_en = 1'b1;
		prog_busy = 1'b0;
		tx_valid = 1'b0;
		tx_data = 8'h00;
		fail_count = 0;
		total_checks = 0;
		t_fall = 0;
		t_rise = 0;
		repeat (16) @(posedge core_clk);
		@(negedge core_clk);
		rstn = 1'b1;
		test_idle();
		test_write();
		test_restart_read();
		test_refuse();
		test_freeze();
		test_write();
		stop_test();
	end
endmodule // test_two_wire_slave_bus_conditions
